// ==== verilog/vlms_defs.svh ====
// How it works
// - Hold a 16-bit upper output-voltage limit at code 0x24; target never settles above it.
// - While converting, an over-limit request ramps the target to the limit and warns.
// - A limit warning sets other-fault, status-word output, min/max warning and alert on the same edge.
// - Writing a limit below the active target gives the same clamp and warning.
// - Margin-high value at code 0x25, relative or absolute; selected target is it plus trim.
// - Margin-low value at code 0x26, relative or absolute; selected target is it plus trim.
// - Margin plus trim is valid only inside the range the current limit allows.
// - Out-of-range margin or slew writes are invalid data: flag status and alert.
// - Slew rate at code 0x27 paces every voltage change in conversion, not turn on/off.
// - Slew word is 5-bit exponent (reset -4) over 11-bit two's-complement mantissa.
// - Any valid slew word reads back unchanged; applied rate is the nearest hardware rate.
// - Supported slew span is 0.067 to 15.933 mV/us; outside it is invalid data.
// - Limit powers up from storage or pin detection; writes act at once.
// - Trim is a 16-bit two's-complement offset added to command and margin targets.
// - Sum above DAC range but under the limit clamps at DAC maximum without warning.
`ifndef VLMS_DEFS_SVH
`define VLMS_DEFS_SVH

`define VLMS_CODE_LIMIT 8'h24
`define VLMS_CODE_MHIGH 8'h25
`define VLMS_CODE_MLOW 8'h26
`define VLMS_CODE_RATE 8'h27

`define VLMS_RATE_EXP_MSB 15
`define VLMS_RATE_EXP_LSB 11
`define VLMS_RATE_MAN_MSB 10
`define VLMS_RATE_EXP_RST 5'h1c
`define VLMS_RATE_MAN_RST 11'h010

`define VLMS_LIMIT_RST 16'h0000
`define VLMS_MHIGH_RST 16'h0000
`define VLMS_MLOW_RST 16'h0000
`define VLMS_TARGET_RST 16'h0000
`define VLMS_DAC_MAX 16'h0b33

// Rates are handled internally in 1/1024 mV/us.
`define VLMS_RATE_FRAC_BITS 7'sd10
`define VLMS_RATE_MIN 40'h0000000045
`define VLMS_RATE_MAX 40'h0000003fbb
`define VLMS_HW_RATE_SHIFT 6
`define VLMS_HW_RATE_ROUND 40'h0000000020
`define VLMS_HW_RATE_MIN 8'h01
`define VLMS_HW_RATE_MAX 8'hff
// One target code in 1/1024 mV.
`define VLMS_LSB_FRAC 16'h07d0

`define VLMS_CLK_NS 40
`define VLMS_TICK_NS 1000
`define VLMS_TICK_CYC (`VLMS_TICK_NS / `VLMS_CLK_NS)

`endif

// ==== verilog/vlms_pkg.sv ====
`default_nettype none
package vlms_pkg;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [15:0] data;
	} vlms_cmd_s;

	typedef struct packed {
		logic otherFault;
		logic wordVout;
		logic maxMinWarn;
		logic invalidData;
		logic alert;
	} vlms_stat_s;

	typedef enum logic [1:0] {
		MARGIN_NONE = 2'h0,
		MARGIN_LOW = 2'h1,
		MARGIN_HIGH = 2'h2
	} vlms_margin_e;

	typedef enum logic [1:0] {
		SLEW_HOLD = 2'h0,
		SLEW_RISE = 2'h1,
		SLEW_FALL = 2'h2
	} vlms_slew_e;

endpackage : vlms_pkg
`default_nettype wire

// ==== verilog/vlms_slew_step.sv ====
`include "vlms_defs.svh"
`default_nettype none
module vlms_slew_step
	import vlms_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [7:0] hwRate,
	output logic stepEn_r
);

	logic [4:0] divCnt_r;
	logic [15:0] acc_r;
	logic tick;
	logic [15:0] addVal;
	logic [15:0] subVal;

	assign tick = (divCnt_r == 5'(`VLMS_TICK_CYC - 1));
	assign addVal = tick ? (16'(hwRate) << `VLMS_HW_RATE_SHIFT) : 16'h0000;
	assign subVal = (acc_r >= `VLMS_LSB_FRAC) ? `VLMS_LSB_FRAC : 16'h0000;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			divCnt_r <= 5'h00;
		end else if (tick) begin
			divCnt_r <= 5'h00;
		end else begin
			divCnt_r <= divCnt_r + 5'h01;
		end
	end

	// Rate credit per microsecond is spent one code at a time, so fractional rates
	// carry over between ticks instead of being lost.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acc_r <= 16'h0000;
			stepEn_r <= 1'b0;
		end else if (!run) begin
			acc_r <= 16'h0000;
			stepEn_r <= 1'b0;
		end else begin
			acc_r <= acc_r + addVal - subVal;
			stepEn_r <= (acc_r >= `VLMS_LSB_FRAC);
		end
	end

endmodule : vlms_slew_step
`default_nettype wire

// ==== verilog/vlms_core.sv ====
`include "vlms_defs.svh"
`default_nettype none
module vlms_core
	import vlms_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire vlms_cmd_s cmd,
	input wire logic convEnable,
	input wire logic [1:0] marginSel,
	input wire logic modeRelative,
	input wire logic [15:0] voutCommand,
	input wire logic [15:0] voutTrim,
	input wire logic limitFromPin,
	input wire logic [15:0] pinLimit,
	input wire logic [15:0] nvmLimit,
	input wire logic clearStatus,
	output logic [15:0] rdData_r,
	output logic rdValid_r,
	output logic [15:0] target_r,
	output vlms_stat_s status_r
);

	logic [15:0] limit_r;
	logic [15:0] marginHigh_r;
	logic [15:0] marginLow_r;
	logic [15:0] rate_r;
	logic loadPend_r;
	logic [17:0] reqPrev_r;
	logic limitWrote_r;
	logic [7:0] hwRate_r;
	vlms_slew_e slew_r;

	logic signed [17:0] reqSum;
	logic overLimit;
	logic [15:0] dest;
	logic wrEn;
	logic rdEn;
	logic limitBelow;
	logic marginBad;
	logic rateBad;
	logic warnEvent;
	logic badEvent;
	logic stepEn;
	logic [39:0] rateNew;

	// Slew word to rate in 1/1024 mV/us; a negative mantissa decodes as zero.
	function automatic logic [39:0] rateFrac(input logic [15:0] w);
		logic signed [6:0] sh;
		logic [6:0] nsh;
		logic [39:0] r;
		sh = $signed({{2{w[`VLMS_RATE_EXP_MSB]}}, w[`VLMS_RATE_EXP_MSB:`VLMS_RATE_EXP_LSB]})
			+ `VLMS_RATE_FRAC_BITS;
		nsh = 7'h00 - sh;
		r = {29'h0000000, w[`VLMS_RATE_MAN_MSB:0]};
		if (w[`VLMS_RATE_MAN_MSB]) begin
			r = 40'h0000000000;
		end else if (!sh[6]) begin
			r = r << sh[5:0];
		end else begin
			r = r >> nsh[5:0];
		end
		return r;
	endfunction : rateFrac

	// Margin value plus trim, honouring relative or absolute mode.
	function automatic logic signed [17:0] withTrim(input logic [15:0] m, input logic rel,
			input logic [15:0] cmdv, input logic [15:0] trim);
		logic signed [17:0] b;
		b = rel ? $signed({2'b00, cmdv}) + $signed({2'b00, m}) : $signed({2'b00, m});
		return b + $signed({{2{trim[15]}}, trim});
	endfunction : withTrim

	assign wrEn = cmd.valid & cmd.write & ~loadPend_r;
	assign rdEn = cmd.valid & ~cmd.write;
	assign rateNew = rateFrac(cmd.data);

	always_comb begin
		case (marginSel)
			MARGIN_HIGH: reqSum = withTrim(marginHigh_r, modeRelative, voutCommand, voutTrim);
			MARGIN_LOW: reqSum = withTrim(marginLow_r, modeRelative, voutCommand, voutTrim);
			default: reqSum = withTrim(voutCommand, 1'b0, voutCommand, voutTrim);
		endcase
	end

	assign overLimit = reqSum > $signed({2'b00, limit_r});

	// The limit wins over everything; the DAC ceiling only trims silently.
	always_comb begin
		if (reqSum[17]) begin
			dest = 16'h0000;
		end else if (overLimit) begin
			dest = (limit_r > `VLMS_DAC_MAX) ? `VLMS_DAC_MAX : limit_r;
		end else if (reqSum[15:0] > `VLMS_DAC_MAX || reqSum[16]) begin
			dest = `VLMS_DAC_MAX;
		end else begin
			dest = reqSum[15:0];
		end
	end

	always_comb begin
		marginBad = 1'b0;
		if (cmd.code == `VLMS_CODE_MHIGH || cmd.code == `VLMS_CODE_MLOW) begin
			marginBad = withTrim(cmd.data, modeRelative, voutCommand, voutTrim)
				> $signed({2'b00, limit_r});
		end
	end

	assign rateBad = (rateNew < `VLMS_RATE_MIN) || (rateNew > `VLMS_RATE_MAX);
	assign limitBelow = wrEn && cmd.code == `VLMS_CODE_LIMIT && cmd.data < target_r;

	assign warnEvent = convEnable & (limitBelow
		| (overLimit & ((reqSum != $signed(reqPrev_r)) | limitWrote_r)));
	assign badEvent = wrEn & (((cmd.code == `VLMS_CODE_MHIGH || cmd.code == `VLMS_CODE_MLOW)
		& marginBad) | (cmd.code == `VLMS_CODE_RATE & rateBad));

	// The limit default is caught one edge after reset release, never under reset.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			loadPend_r <= 1'b1;
			limit_r <= `VLMS_LIMIT_RST;
		end else if (loadPend_r) begin
			loadPend_r <= 1'b0;
			limit_r <= limitFromPin ? pinLimit : nvmLimit;
		end else if (wrEn && cmd.code == `VLMS_CODE_LIMIT) begin
			limit_r <= cmd.data;
		end
	end

	// Rejected words are not stored, so the registers hold only words that were valid when written.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			marginHigh_r <= `VLMS_MHIGH_RST;
			marginLow_r <= `VLMS_MLOW_RST;
			rate_r <= {`VLMS_RATE_EXP_RST, `VLMS_RATE_MAN_RST};
		end else if (wrEn && !marginBad && cmd.code == `VLMS_CODE_MHIGH) begin
			marginHigh_r <= cmd.data;
		end else if (wrEn && !marginBad && cmd.code == `VLMS_CODE_MLOW) begin
			marginLow_r <= cmd.data;
		end else if (wrEn && !rateBad && cmd.code == `VLMS_CODE_RATE) begin
			rate_r <= cmd.data;
		end
	end

	// Nearest supported rate; the stored word itself is left untouched.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hwRate_r <= `VLMS_HW_RATE_MIN;
		end else begin
			hwRate_r <= 8'((rateFrac(rate_r) + `VLMS_HW_RATE_ROUND) >> `VLMS_HW_RATE_SHIFT);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdData_r <= 16'h0000;
			rdValid_r <= 1'b0;
		end else begin
			rdValid_r <= rdEn;
			case (cmd.code)
				`VLMS_CODE_LIMIT: rdData_r <= limit_r;
				`VLMS_CODE_MHIGH: rdData_r <= marginHigh_r;
				`VLMS_CODE_MLOW: rdData_r <= marginLow_r;
				`VLMS_CODE_RATE: rdData_r <= rate_r;
				default: rdData_r <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reqPrev_r <= 18'h00000;
			limitWrote_r <= 1'b0;
		end else begin
			reqPrev_r <= reqSum;
			limitWrote_r <= wrEn && cmd.code == `VLMS_CODE_LIMIT;
		end
	end

	vlms_slew_step u_step (
		.clk(clk),
		.reset(reset),
		.run(convEnable && slew_r != SLEW_HOLD),
		.hwRate(hwRate_r),
		.stepEn_r(stepEn)
	);

	// Outside conversion the target follows at once: turn-on and turn-off
	// are not paced by this rate.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			target_r <= `VLMS_TARGET_RST;
			slew_r <= SLEW_HOLD;
		end else if (!convEnable) begin
			target_r <= dest;
			slew_r <= SLEW_HOLD;
		end else begin
			case (slew_r)
				SLEW_HOLD: begin
					if (dest > target_r) begin
						slew_r <= SLEW_RISE;
					end else if (dest < target_r) begin
						slew_r <= SLEW_FALL;
					end
				end
				SLEW_RISE: begin
					if (dest <= target_r) begin
						slew_r <= SLEW_HOLD;
					end else if (stepEn) begin
						target_r <= target_r + 16'h0001;
					end
				end
				SLEW_FALL: begin
					if (dest >= target_r) begin
						slew_r <= SLEW_HOLD;
					end else if (stepEn) begin
						target_r <= target_r - 16'h0001;
					end
				end
				default: slew_r <= SLEW_HOLD;
			endcase
		end
	end

	// A new event in the clearing cycle survives the clear.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status_r <= '0;
		end else begin
			status_r.otherFault <= warnEvent | (status_r.otherFault & ~clearStatus);
			status_r.wordVout <= warnEvent | (status_r.wordVout & ~clearStatus);
			status_r.maxMinWarn <= warnEvent | (status_r.maxMinWarn & ~clearStatus);
			status_r.invalidData <= badEvent | (status_r.invalidData & ~clearStatus);
			status_r.alert <= warnEvent | badEvent | (status_r.alert & ~clearStatus);
		end
	end

endmodule : vlms_core
`default_nettype wire

// ==== testbench/vlms_core_properties.sv ====
`include "vlms_defs.svh"
`default_nettype none
module vlms_core_properties
	import vlms_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire vlms_cmd_s cmd,
	input wire logic convEnable,
	input wire logic clearStatus,
	input wire logic [15:0] rdData_r,
	input wire logic rdValid_r,
	input wire logic [15:0] target_r,
	input wire vlms_stat_s status_r
);
	timeunit 1ns;
	timeprecision 1ns;
	logic goodRate;
	logic [15:0] lastRate_r;
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// Only in-range words with the reset exponent are mirrored; others would need a full decode.
	assign goodRate = cmd.valid && cmd.write && cmd.code == 8'h27 && cmd.data[15:8] == 8'he0
		&& cmd.data[7:0] > 8'h01 && cmd.data[7:0] < 8'hff;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lastRate_r <= 16'he010;
		end else if (goodRate) begin
			lastRate_r <= cmd.data;
		end
	end
	sequence rateRd;
		cmd.valid && !cmd.write && cmd.code == 8'h27;
	endsequence
	sequence rateBad;
		cmd.valid && cmd.write && cmd.code == 8'h27 && (cmd.data[10] || cmd.data[10:0] == 11'h0);
	endsequence
	rd_answer_a: assert property (rdValid_r == $past(cmd.valid && !cmd.write))
		else $error("read answer pulse wrong");
	unmapped_zero_a: assert property (cmd.valid && !cmd.write &&
		(cmd.code < 8'h24 || cmd.code > 8'h27) |=> rdData_r == 16'h0000)
		else $error("unmapped read not zero");
	rate_back_a: assert property (rateRd |=> rdData_r == lastRate_r)
		else $error("rate word not read back");
	rate_bad_a: assert property (rateBad |=> status_r.invalidData && status_r.alert)
		else $error("bad rate not flagged");
	dac_cap_a: assert property (target_r <= `VLMS_DAC_MAX)
		else $error("target above converter range");
	warn_bits_a: assert property ($rose(status_r.maxMinWarn) |->
		status_r.otherFault && status_r.wordVout && status_r.alert)
		else $error("warning without companion bits");
	alert_hold_a: assert property (status_r.alert && !clearStatus |=> status_r.alert)
		else $error("alert dropped");
	slew_step_a: assert property (convEnable && $past(convEnable) |->
		16'(target_r - $past(target_r) + 16'h0001) <= 16'h0002)
		else $error("target jumped while converting");
endmodule : vlms_core_properties
bind vlms_core vlms_core_properties vlms_core_properties_inst (.*);
`default_nettype wire

// ==== testbench/vlms_host.sv ====
`default_nettype none
module vlms_host
	import vlms_pkg::*;
(
	input wire logic clk,
	output var vlms_cmd_s cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial cmd = '0;
	// A released bus shows the inverse word, so sampling outside the strobe never matches by luck.
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input int g);
		repeat (g + 1) @(posedge clk);
		cmd <= '{1'b1, w, c, d};
		@(posedge clk);
		cmd <= '{1'b0, w, ~c, ~d};
	endtask : xfer
endmodule : vlms_host
`default_nettype wire

// ==== testbench/tb.sv ====
`include "vlms_defs.svh"
`default_nettype none
module tb
	import vlms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset, convEnable, modeRelative, limitFromPin, clearStatus, rdValid_r;
	logic [1:0] marginSel;
	logic [15:0] voutCommand, voutTrim, pinLimit, nvmLimit, rdData_r, target_r, w;
	logic [31:0] seed = 32'h5294;
	logic [15:0] bad [4] = '{16'he001, 16'he0ff, 16'he7ff, 16'he000};
	vlms_cmd_s cmd;
	vlms_stat_s status_r;
	int miscompares, nTests, n;
	vlms_core vlms_core_inst (.*);
	vlms_host vlms_host_inst (.*);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [15:0] expDest(input logic [15:0] s, input logic [15:0] lim);
		logic [15:0] d;
		d = (s > lim) ? lim : s;
		return (d > `VLMS_DAC_MAX) ? `VLMS_DAC_MAX : d;
	endfunction : expDest
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		nTests++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		vlms_host_inst.xfer(1'b1, c, d, rnd() % 3);
	endtask : wr
	task automatic rdk(input logic [7:0] c, input logic [15:0] e);
		vlms_host_inst.xfer(1'b0, c, 16'h0000, rnd() % 3);
		#1;
		chk("rdValid", 16'h0001, {15'h0, rdValid_r});
		chk("rdData", e, rdData_r);
		@(posedge clk);
	endtask : rdk
	task automatic stc(input logic [4:0] e);
		repeat (2) @(posedge clk);
		#1;
		chk("status", {11'h0, e}, {11'h0, status_r});
		@(posedge clk);
		clearStatus <= 1'b1;
		@(posedge clk);
		clearStatus <= 1'b0;
	endtask : stc
	task automatic waitT(input logic [15:0] e);
		n = 0;
		#1;
		while (target_r !== e && n < 600) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("target", e, target_r);
		// Realign to the edge so that callers drive inputs on it.
		@(posedge clk);
	endtask : waitT
	task automatic tally_and_finish();
		$display("Counts: %0d checks, %0d mismatches", nTests, miscompares);
		if (miscompares == 0 && nTests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#400000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		reset = 1'b1;
		convEnable = 1'b0;
		marginSel = 2'h0;
		modeRelative = 1'b0;
		voutCommand = 16'h0400;
		voutTrim = 16'h0000;
		limitFromPin = 1'b1;
		pinLimit = 16'h0800;
		nvmLimit = 16'h0100;
		clearStatus = 1'b0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rdk(8'h24, 16'h0800);
		rdk(8'h27, 16'he010);
		wr(8'h30, 16'h1234);
		rdk(8'h30, 16'h0000);
		$display("Test reset done");
		for (int i = 0; i < 8; i++) begin
			w = {8'he0, (i == 0) ? 8'h02 : (i == 7) ? 8'hfe : 8'(rnd() % 253 + 2)};
			wr(8'h27, w);
			rdk(8'h27, w);
		end
		foreach (bad[i]) begin
			wr(8'h27, bad[i]);
			stc(5'h03);
			rdk(8'h27, w);
		end
		$display("Test rate done");
		wr(8'h25, 16'h0300);
		marginSel <= 2'h2;
		waitT(16'h0300);
		wr(8'h26, 16'h0010);
		modeRelative <= 1'b1;
		marginSel <= 2'h1;
		waitT(16'h0410);
		modeRelative <= 1'b0;
		voutTrim <= 16'hfff0;
		waitT(16'h0000);
		voutTrim <= 16'h0000;
		wr(8'h25, 16'h0900);
		stc(5'h03);
		rdk(8'h25, 16'h0300);
		marginSel <= 2'h0;
		waitT(16'h0400);
		$display("Test margin done");
		wr(8'h24, 16'h0f00);
		voutCommand <= 16'h0b20;
		waitT(16'h0b20);
		convEnable <= 1'b1;
		voutCommand <= 16'h0c00;
		waitT(expDest(16'h0c00, 16'h0f00));
		stc(5'h00);
		convEnable <= 1'b0;
		voutCommand <= 16'h0400;
		waitT(16'h0400);
		convEnable <= 1'b1;
		wr(8'h24, 16'h03f0);
		waitT(16'h03f0);
		chk("rampCycles", 16'h0001, {15'h0, n >= 16});
		stc(5'h1d);
		voutCommand <= 16'h0500;
		stc(5'h1d);
		chk("target", 16'h03f0, target_r);
		$display("Test clamp done");
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
